// ---- inc/wake_irq_pkg.sv ----
// package: register map, field positions and carrier types for the wake block
package wake_irq_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] OFF_WAKE_STS3  = 8'h00;
    localparam logic [7:0] OFF_WAKE_EN3   = 8'h01;
    localparam logic [7:0] OFF_WAKE_STS5  = 8'h02;
    localparam logic [7:0] OFF_WAKE_EN5   = 8'h03;
    localparam logic [7:0] OFF_WAKE_PSTS  = 8'h04;
    localparam logic [7:0] OFF_WAKE_PEN   = 8'h05;
    localparam logic [7:0] OFF_MGMT_STS1  = 8'h06;
    localparam logic [7:0] OFF_MGMT_STS2  = 8'h07;
    localparam logic [7:0] OFF_MGMT_STS3  = 8'h08;
    localparam logic [7:0] OFF_MGMT_EN1   = 8'h09;
    localparam logic [7:0] OFF_MGMT_EN2   = 8'h0a;
    localparam logic [7:0] OFF_MGMT_EN3   = 8'h0b;
    localparam logic [7:0] OFF_MGMT_EN4   = 8'h0c;
    localparam logic [7:0] OFF_GPIO_POL   = 8'h0d;
    localparam logic [7:0] OFF_GPIO_EDGE  = 8'h0e;
    localparam logic [7:0] OFF_WAKE_CTL   = 8'h0f;
    localparam logic [7:0] OFF_MGMT_CTL   = 8'h10;
    localparam logic [7:0] OFF_MGMT_STS4  = 8'h11;
    localparam logic [7:0] OFF_WAKE_STS6  = 8'h12;
    localparam logic [7:0] OFF_WAKE_EN6   = 8'h13;

    // field positions
    localparam int GRP_IRQ_BIT     = 3;
    localparam int EN2_PIN_BIT     = 7;
    localparam int EN2_SERIRQ_BIT  = 6;
    localparam int EN2_WAKE_BIT    = 5;
    localparam int CTL_POL_BIT     = 1;
    localparam int CTL_FUNC_BIT    = 2;
    localparam int CTL_DRV_BIT     = 7;
    localparam int IR_BIT          = 0;

    // reset values: polarity bit clear means active low, bit 7 clear open drain
    localparam logic [7:0] RST_PIN_CTL  = 8'h00;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_WAKE_EN6 = 8'hff;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       out;
        logic       oe;
    } pin_drive_t;

    // drive of a wake or management pin from active flag and control byte
    function automatic pin_drive_t drive_pin(input logic act,
                                             input logic [7:0] ctl);
        pin_drive_t d;
        logic lvl;
        lvl   = act ^ ~ctl[CTL_POL_BIT];
        d.out = lvl;
        d.oe  = ctl[CTL_DRV_BIT] ? 1'b1 : ~lvl;
        return d;
    endfunction
endpackage

// ---- rtl/wake_and_mgmt_irq_aggregator.sv ----
// wake and management interrupt aggregator, one clock domain
`timescale 1ns/1ps
module wake_and_mgmt_irq_aggregator
    import wake_irq_pkg::*;
#(
    parameter int NGPIO = 8,
    parameter int NTACH = 2,
    parameter int NDEV  = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [7:0]       regAddr,
    input  wire logic [7:0]       regWdata,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [7:0]       regRdata,
    input  wire logic [NGPIO-1:0] gpioIn,
    input  wire logic [NTACH-1:0] tachIn,
    input  wire logic [NDEV-1:0]  devEvent,
    input  wire logic [1:0]       hwmEvent,
    input  wire logic [7:0]       wakePinGpioControl,
    input  wire logic [7:0]       mgmtPinGpioControl,
    output logic                  wakeOutputPinOut,
    output logic                  wakeOutputPinOe,
    output logic                  mgmtIrqOutputPinOut,
    output logic                  mgmtIrqOutputPinOe,
    output logic                  serIrq2Req
);
    // tach polarity shares the low write bits, so at most 8 tach pins
    if (NGPIO != 8 || NTACH < 1 || NTACH > 8 || NDEV != 8) begin : gBadWidths
        $error("unsupported widths");
    end

    localparam int NPIN = NGPIO + NTACH;

    reg_req_t req;
    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    function automatic logic hit_wr(input reg_req_t r,
                                    input logic [7:0] off);
        return r.wr && r.addr == off;
    endfunction

    logic [NPIN-1:0] pinMeta_ff, pinSync_ff, pinLast_ff;
    logic [NDEV-1:0] devMeta_ff, devSync_ff;
    logic [1:0]      hwmMeta_ff, hwmSync_ff, hwmLast_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            pinMeta_ff <= '0;
            pinSync_ff <= '0;
            pinLast_ff <= '0;
            devMeta_ff <= '0;
            devSync_ff <= '0;
            hwmMeta_ff <= '0;
            hwmSync_ff <= '0;
            hwmLast_ff <= '0;
        end else begin
            pinMeta_ff <= {tachIn, gpioIn};
            pinSync_ff <= pinMeta_ff;
            pinLast_ff <= pinSync_ff;
            devMeta_ff <= devEvent;
            devSync_ff <= devMeta_ff;
            hwmMeta_ff <= hwmEvent;
            hwmSync_ff <= hwmMeta_ff;
            hwmLast_ff <= hwmSync_ff;
        end
    end

    // control registers
    logic [NPIN-1:0] pinPol_ff;
    logic [NGPIO-1:0] eitherEdgeTrigger_ff;
    logic [7:0] wakeEnable3_ff, wakeEnable5_ff, wakeEnable6_ff;
    logic [7:0] wakePinEnable_ff;
    logic [7:0] mgmtIrqEnable1_ff, mgmtIrqEnable2_ff;
    logic [7:0] mgmtIrqEnable3_ff, mgmtIrqEnable4_ff;
    logic       wakeFuncSel_ff, mgmtFuncSel_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            pinPol_ff            <= '0;
            eitherEdgeTrigger_ff <= '0;
            wakeEnable3_ff       <= RST_ZERO;
            wakeEnable5_ff       <= RST_ZERO;
            wakeEnable6_ff       <= RST_WAKE_EN6;
            wakePinEnable_ff     <= RST_ZERO;
            mgmtIrqEnable1_ff    <= RST_ZERO;
            mgmtIrqEnable2_ff    <= RST_ZERO;
            mgmtIrqEnable3_ff    <= RST_ZERO;
            mgmtIrqEnable4_ff    <= RST_ZERO;
            // pins start on their gpio function
            wakeFuncSel_ff       <= 1'b0;
            mgmtFuncSel_ff       <= 1'b0;
        end else begin
            if (hit_wr(req, OFF_GPIO_POL))
                pinPol_ff <= NPIN'({regWdata[NTACH-1:0], regWdata});
            if (hit_wr(req, OFF_GPIO_EDGE))
                eitherEdgeTrigger_ff <= regWdata;
            if (hit_wr(req, OFF_WAKE_EN3))  wakeEnable3_ff <= regWdata;
            if (hit_wr(req, OFF_WAKE_EN5))  wakeEnable5_ff <= regWdata;
            if (hit_wr(req, OFF_WAKE_EN6))  wakeEnable6_ff <= regWdata;
            if (hit_wr(req, OFF_WAKE_PEN))  wakePinEnable_ff <= regWdata;
            if (hit_wr(req, OFF_MGMT_EN1))  mgmtIrqEnable1_ff <= regWdata;
            if (hit_wr(req, OFF_MGMT_EN2))  mgmtIrqEnable2_ff <= regWdata;
            if (hit_wr(req, OFF_MGMT_EN3))  mgmtIrqEnable3_ff <= regWdata;
            if (hit_wr(req, OFF_MGMT_EN4))  mgmtIrqEnable4_ff <= regWdata;
            if (hit_wr(req, OFF_WAKE_CTL))
                wakeFuncSel_ff <= regWdata[CTL_FUNC_BIT];
            if (hit_wr(req, OFF_MGMT_CTL))
                mgmtFuncSel_ff <= regWdata[CTL_FUNC_BIT];
        end
    end

    // edge detection on synchronised pins
    logic [NPIN-1:0] rise, fall, pinHit;
    always_comb begin
        rise = pinSync_ff & ~pinLast_ff;
        fall = ~pinSync_ff & pinLast_ff;
        pinHit = (rise & ~pinPol_ff) | (fall & pinPol_ff);
        pinHit[NGPIO-1:0] = pinHit[NGPIO-1:0]
                          | (eitherEdgeTrigger_ff & (rise[NGPIO-1:0]
                          | fall[NGPIO-1:0]));
    end
    logic [1:0] hwmRise;
    assign hwmRise = hwmSync_ff & ~hwmLast_ff;

    // sticky status registers
    logic [7:0] mgmtIrqStatus3_ff, mgmtIrqStatus4_ff;
    logic [7:0] wakeStatus5_ff, wakeStatus6_ff;
    logic [7:0] wakeStatus3Sticky_ff;
    logic [7:0] nxt_mgmtIrqStatus3, nxt_mgmtIrqStatus4;
    logic [7:0] nxt_wakeStatus5, nxt_wakeStatus6, nxt_wakeStatus3;
    logic [7:0] tachSet;
    always_comb begin
        tachSet = '0;
        tachSet[NTACH-1:0] = pinHit[NPIN-1:NGPIO];
        // hardware set is or-ed after the clear, so it wins
        // write one clears gpio management bits
        nxt_mgmtIrqStatus3 = mgmtIrqStatus3_ff;
        if (hit_wr(req, OFF_MGMT_STS3))
            nxt_mgmtIrqStatus3 = nxt_mgmtIrqStatus3 & ~regWdata;
        nxt_mgmtIrqStatus3 = nxt_mgmtIrqStatus3 | pinHit[NGPIO-1:0];
        nxt_mgmtIrqStatus4 = mgmtIrqStatus4_ff;
        if (hit_wr(req, OFF_MGMT_STS4))
            nxt_mgmtIrqStatus4 = nxt_mgmtIrqStatus4 & ~regWdata;
        nxt_mgmtIrqStatus4 = nxt_mgmtIrqStatus4 | tachSet;
        // wake bits sticky until write one
        nxt_wakeStatus5 = wakeStatus5_ff;
        if (hit_wr(req, OFF_WAKE_STS5))
            nxt_wakeStatus5 = nxt_wakeStatus5 & ~regWdata;
        nxt_wakeStatus5 = nxt_wakeStatus5 | pinHit[NGPIO-1:0];
        // monitor events in wake status 6
        nxt_wakeStatus6 = wakeStatus6_ff;
        if (hit_wr(req, OFF_WAKE_STS6))
            nxt_wakeStatus6 = nxt_wakeStatus6 & ~regWdata;
        nxt_wakeStatus6 = nxt_wakeStatus6 | {6'h00, hwmRise};
        nxt_wakeStatus3 = wakeStatus3Sticky_ff;
        if (hit_wr(req, OFF_WAKE_STS3))
            nxt_wakeStatus3 = nxt_wakeStatus3 & ~regWdata;
        nxt_wakeStatus3[GRP_IRQ_BIT] = 1'b0;
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            mgmtIrqStatus3_ff    <= RST_ZERO;
            mgmtIrqStatus4_ff    <= RST_ZERO;
            wakeStatus5_ff       <= RST_ZERO;
            wakeStatus6_ff       <= RST_ZERO;
            wakeStatus3Sticky_ff <= RST_ZERO;
        end else begin
            mgmtIrqStatus3_ff    <= nxt_mgmtIrqStatus3;
            mgmtIrqStatus4_ff    <= nxt_mgmtIrqStatus4;
            wakeStatus5_ff       <= nxt_wakeStatus5;
            wakeStatus6_ff       <= nxt_wakeStatus6;
            wakeStatus3Sticky_ff <= nxt_wakeStatus3;
        end
    end

    // infrared flag: set by source, cleared by status 2 read
    logic infraredEvent_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            infraredEvent_ff <= 1'b0;
        end else if (devSync_ff[IR_BIT]) begin
            infraredEvent_ff <= 1'b1;
        end else if (regRd && regAddr == OFF_MGMT_STS2) begin
            infraredEvent_ff <= 1'b0;
        end
    end

    // device bits follow source, ir bit too; status 2 shows the ir latch
    logic [7:0] mgmtIrqStatus1, mgmtIrqStatus2;
    always_comb begin
        mgmtIrqStatus1 = devSync_ff;
        mgmtIrqStatus2 = 8'h00;
        mgmtIrqStatus2[IR_BIT] = infraredEvent_ff;
    end

    // group irq from all enabled sources
    logic groupIrq;
    always_comb begin
        groupIrq = |(mgmtIrqStatus1 & mgmtIrqEnable1_ff)
            | |(mgmtIrqStatus2[IR_BIT] & mgmtIrqEnable2_ff[IR_BIT])
            | |(mgmtIrqStatus3_ff & mgmtIrqEnable3_ff)
            | |(mgmtIrqStatus4_ff & mgmtIrqEnable4_ff);
    end

    // group irq reflected in wake status 3
    logic [7:0] wakeStatus3;
    always_comb begin
        wakeStatus3 = wakeStatus3Sticky_ff;
        wakeStatus3[GRP_IRQ_BIT] = groupIrq
                                 & mgmtIrqEnable2_ff[EN2_WAKE_BIT];
    end

    // enabled wake status sets pin status
    logic wakeAny;
    assign wakeAny = |(wakeStatus3 & wakeEnable3_ff)
                   | |(wakeStatus5_ff & wakeEnable5_ff)
                   | |(wakeStatus6_ff & wakeEnable6_ff);

    logic wakePinStatus_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            wakePinStatus_ff <= 1'b0;
        end else if (wakeAny) begin
            wakePinStatus_ff <= 1'b1;
        end else if (hit_wr(req, OFF_WAKE_PSTS) && regWdata[0]) begin
            wakePinStatus_ff <= 1'b0;
        end
    end

    // pin drivers; pins idle released until their function is chosen
    pin_drive_t wakeDrv, mgmtDrv;
    always_comb begin
        // wake asserted from pin status and enable
        // polarity and driver from control byte
        wakeDrv = drive_pin(wakePinStatus_ff & wakePinEnable_ff[0],
                            wakePinGpioControl);
        if (!wakeFuncSel_ff) wakeDrv = '{out: 1'b0, oe: 1'b0};
        // management pin gated by enable 2 bit 7
        mgmtDrv = drive_pin(groupIrq & mgmtIrqEnable2_ff[EN2_PIN_BIT],
                            mgmtPinGpioControl);
        if (!mgmtFuncSel_ff) mgmtDrv = '{out: 1'b0, oe: 1'b0};
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            wakeOutputPinOut    <= 1'b0;
            wakeOutputPinOe     <= 1'b0;
            mgmtIrqOutputPinOut <= 1'b0;
            mgmtIrqOutputPinOe  <= 1'b0;
            serIrq2Req          <= 1'b0;
        end else begin
            wakeOutputPinOut    <= wakeDrv.out;
            wakeOutputPinOe     <= wakeDrv.oe;
            mgmtIrqOutputPinOut <= mgmtDrv.out;
            mgmtIrqOutputPinOe  <= mgmtDrv.oe;
            // route to serial irq channel 2
            serIrq2Req <= groupIrq & mgmtIrqEnable2_ff[EN2_SERIRQ_BIT];
        end
    end

    // read port; data stand the cycle after the strobe only
    logic [7:0] rdMux;
    always_comb begin
        case (regAddr)
            OFF_WAKE_STS3: rdMux = wakeStatus3;
            OFF_WAKE_EN3:  rdMux = wakeEnable3_ff;
            OFF_WAKE_STS5: rdMux = wakeStatus5_ff;
            OFF_WAKE_EN5:  rdMux = wakeEnable5_ff;
            OFF_WAKE_STS6: rdMux = wakeStatus6_ff;
            OFF_WAKE_EN6:  rdMux = wakeEnable6_ff;
            OFF_WAKE_PSTS: rdMux = {7'h00, wakePinStatus_ff};
            OFF_WAKE_PEN:  rdMux = wakePinEnable_ff;
            OFF_MGMT_STS1: rdMux = mgmtIrqStatus1;
            OFF_MGMT_STS2: rdMux = mgmtIrqStatus2;
            OFF_MGMT_STS3: rdMux = mgmtIrqStatus3_ff;
            OFF_MGMT_STS4: rdMux = mgmtIrqStatus4_ff;
            OFF_MGMT_EN1:  rdMux = mgmtIrqEnable1_ff;
            OFF_MGMT_EN2:  rdMux = mgmtIrqEnable2_ff;
            OFF_MGMT_EN3:  rdMux = mgmtIrqEnable3_ff;
            OFF_MGMT_EN4:  rdMux = mgmtIrqEnable4_ff;
            OFF_GPIO_POL:  rdMux = pinPol_ff[7:0];
            OFF_GPIO_EDGE: rdMux = eitherEdgeTrigger_ff;
            OFF_WAKE_CTL:  rdMux = {5'h00, wakeFuncSel_ff, 2'h0};
            OFF_MGMT_CTL:  rdMux = {5'h00, mgmtFuncSel_ff, 2'h0};
            default:       rdMux = 8'h00;
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            regRdata <= rdMux;
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule

// ---- tb/wake_irq_sva.sv ----
// checker: port-level timing of the wake and management block
`timescale 1ns/1ps
module wake_irq_sva
    import wake_irq_pkg::*;
#(
    parameter int NGPIO = 8,
    parameter int NTACH = 2,
    parameter int NDEV  = 8
) (
    input wire logic             clock,
    input wire logic             rst,
    input wire logic [7:0]       regAddr,
    input wire logic [7:0]       regWdata,
    input wire logic             regWr,
    input wire logic             regRd,
    input wire logic [7:0]       regRdata,
    input wire logic [NGPIO-1:0] gpioIn,
    input wire logic [NTACH-1:0] tachIn,
    input wire logic [NDEV-1:0]  devEvent,
    input wire logic [1:0]       hwmEvent,
    input wire logic [7:0]       wakePinGpioControl,
    input wire logic [7:0]       mgmtPinGpioControl,
    input wire logic             wakeOutputPinOut,
    input wire logic             wakeOutputPinOe,
    input wire logic             mgmtIrqOutputPinOut,
    input wire logic             mgmtIrqOutputPinOe,
    input wire logic             serIrq2Req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // quiet pins first, so no fresh edge can win over the clear
    sequence s_clr(logic [7:0] a);
        $stable({gpioIn, tachIn, hwmEvent, devEvent})[*8] ##0
        (regWr && regAddr == a && regWdata == 8'hff) ##1
        $stable({gpioIn, tachIn, hwmEvent, devEvent}) ##1
        (regRd && regAddr == a && $stable({gpioIn, tachIn, hwmEvent, devEvent}));
    endsequence

    property p_gm_clr;
        s_clr(OFF_MGMT_STS3) |=> regRdata == 8'h00;
    endproperty
    property p_gw_clr;
        s_clr(OFF_WAKE_STS5) |=> regRdata == 8'h00;
    endproperty
    property p_tach_clr;
        s_clr(OFF_MGMT_STS4) |=> regRdata == 8'h00;
    endproperty
    property p_hwm_clr;
        s_clr(OFF_WAKE_STS6) |=> regRdata[1:0] == 2'b00;
    endproperty
    property p_ir_rd;
        (!devEvent[IR_BIT])[*8] ##0 (regRd && regAddr == OFF_MGMT_STS2)
        ##1 !devEvent[IR_BIT] ##1
        (!devEvent[IR_BIT] && regRd && regAddr == OFF_MGMT_STS2)
        |=> !regRdata[IR_BIT];
    endproperty
    property p_wake_od;
        !wakePinGpioControl[CTL_DRV_BIT] && wakeOutputPinOe &&
        !$past(wakePinGpioControl[CTL_DRV_BIT]) &&
        !$past(wakePinGpioControl[CTL_DRV_BIT], 2) |-> !wakeOutputPinOut;
    endproperty
    property p_mgmt_od;
        !mgmtPinGpioControl[CTL_DRV_BIT] && mgmtIrqOutputPinOe &&
        !$past(mgmtPinGpioControl[CTL_DRV_BIT]) &&
        !$past(mgmtPinGpioControl[CTL_DRV_BIT], 2) |-> !mgmtIrqOutputPinOut;
    endproperty
    property p_rst_rel;
        $fell(rst) |-> !(wakeOutputPinOe || mgmtIrqOutputPinOe || serIrq2Req);
    endproperty

    a_gm_clr: assert property (p_gm_clr) else $error("gpio mgmt clear");
    a_gw_clr: assert property (p_gw_clr) else $error("gpio wake clear");
    a_tach_clr: assert property (p_tach_clr) else $error("tach clear");
    a_hwm_clr: assert property (p_hwm_clr) else $error("hwm clear");
    a_ir_rd: assert property (p_ir_rd) else $error("infrared read");
    a_wake_od: assert property (p_wake_od) else $error("wake drain");
    a_mgmt_od: assert property (p_mgmt_od) else $error("mgmt drain");
    a_rst_rel: assert property (p_rst_rel) else $error("reset pins");
endmodule

bind wake_and_mgmt_irq_aggregator wake_irq_sva #(
    .NGPIO(NGPIO), .NTACH(NTACH), .NDEV(NDEV)
) i_wake_irq_sva (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gpioIn(gpioIn),
    .tachIn(tachIn), .devEvent(devEvent), .hwmEvent(hwmEvent),
    .wakePinGpioControl(wakePinGpioControl),
    .mgmtPinGpioControl(mgmtPinGpioControl),
    .wakeOutputPinOut(wakeOutputPinOut), .wakeOutputPinOe(wakeOutputPinOe),
    .mgmtIrqOutputPinOut(mgmtIrqOutputPinOut),
    .mgmtIrqOutputPinOe(mgmtIrqOutputPinOe), .serIrq2Req(serIrq2Req)
);

// ---- tb/host_chipset_model.sv ----
// host side model: pulled-up wake and management lines
`timescale 1ns/1ps
module host_chipset_model (
    input  wire logic wakeOut,
    input  wire logic wakeOe,
    input  wire logic mgmtOut,
    input  wire logic mgmtOe,
    output logic      wakeLine,
    output logic      mgmtLine
);
    // board pull-up holds a released line high, never the last value
    assign wakeLine = wakeOe ? wakeOut : 1'b1;
    assign mgmtLine = mgmtOe ? mgmtOut : 1'b1;
endmodule

// ---- tb/tb_top.sv ----
// testbench: directed scenarios for the wake and management block
`timescale 1ns/1ps
module tb_top;
    import wake_irq_pkg::*;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic [7:0] regRdata;
    logic [7:0] gpioIn = 8'h00;
    logic [1:0] tachIn = 2'b00;
    logic [7:0] devEvent = 8'h00;
    logic [1:0] hwmEvent = 2'b00;
    logic [7:0] wakeCtl = 8'h00;
    logic [7:0] mgmtCtl = 8'h00;
    logic       wOut, wOe, mOut, mOe, serIrq2Req, wakeLine, mgmtLine;
    logic [7:0] d;
    int         mismatches = 0;
    int         n_checks = 0;

    always #2.5 clock = ~clock;

    wake_and_mgmt_irq_aggregator i_wake_and_mgmt_irq_aggregator (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gpioIn(gpioIn),
        .tachIn(tachIn), .devEvent(devEvent), .hwmEvent(hwmEvent),
        .wakePinGpioControl(wakeCtl), .mgmtPinGpioControl(mgmtCtl),
        .wakeOutputPinOut(wOut), .wakeOutputPinOe(wOe),
        .mgmtIrqOutputPinOut(mOut), .mgmtIrqOutputPinOe(mOe),
        .serIrq2Req(serIrq2Req)
    );
    host_chipset_model i_host_chipset_model (
        .wakeOut(wOut), .wakeOe(wOe), .mgmtOut(mOut), .mgmtOe(mOe),
        .wakeLine(wakeLine), .mgmtLine(mgmtLine)
    );

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        rd(a);
        chk(n, e, d);
    endtask
    // two sync flops, edge flop, status and pin stages
    task automatic settle;
        repeat (8) @(posedge clock);
        #1;
    endtask
    task automatic setGpio(input logic [7:0] v);
        @(posedge clock);
        gpioIn <= v;
        settle;
    endtask
    task automatic clrGpio;
        wr(OFF_MGMT_STS3, 8'hff);
        wr(OFF_WAKE_STS5, 8'hff);
    endtask

    task automatic s_reset;
        #1;
        chk("wake pin", 8'h00, {6'h00, wOe, wOut});
        chk("mgmt pin", 8'h00, {6'h00, mOe, mOut});
        rc(OFF_WAKE_EN6, RST_WAKE_EN6, "wake en6");
        rc(OFF_MGMT_EN2, RST_ZERO, "mgmt en2");
        rc(OFF_WAKE_CTL, RST_ZERO, "wake func");
        wr(8'h20, 8'hff);
        rc(8'h20, 8'h00, "unmapped");
    endtask
    task automatic s_gpio;
        setGpio(8'h01);
        rc(OFF_MGMT_STS3, 8'h01, "mgmt rise");
        rc(OFF_WAKE_STS5, 8'h01, "wake rise");
        wr(OFF_MGMT_STS3, 8'h00);
        rc(OFF_MGMT_STS3, 8'h01, "write zero");
        wr(OFF_MGMT_STS3, 8'hff);
        rc(OFF_MGMT_STS3, 8'h00, "mgmt clr");
        wr(OFF_WAKE_STS5, 8'hff);
        rc(OFF_WAKE_STS5, 8'h00, "wake clr");
        setGpio(8'h00);
        rc(OFF_WAKE_STS5, 8'h00, "wake fall");
        wr(OFF_GPIO_POL, 8'h04);
        settle;
        clrGpio;
        setGpio(8'h04);
        rc(OFF_MGMT_STS3, 8'h00, "inv rise");
        setGpio(8'h00);
        rc(OFF_MGMT_STS3, 8'h04, "inv fall");
        wr(OFF_GPIO_EDGE, 8'h08);
        clrGpio;
        setGpio(8'h08);
        rc(OFF_MGMT_STS3, 8'h08, "either rise");
        clrGpio;
        setGpio(8'h00);
        rc(OFF_WAKE_STS5, 8'h08, "either fall");
        clrGpio;
    endtask
    task automatic s_wake;
        wr(OFF_WAKE_EN5, 8'h01);
        wr(OFF_WAKE_PEN, 8'h01);
        wr(OFF_WAKE_CTL, 8'h04);
        setGpio(8'h01);
        rc(OFF_WAKE_PSTS, 8'h01, "pin status");
        chk("wake line", 8'h00, {7'h00, wakeLine});
        chk("wake od", 8'h02, {6'h00, wOe, wOut});
        @(posedge clock);
        wakeCtl <= 8'h82;
        settle;
        chk("wake pp high", 8'h03, {6'h00, wOe, wOut});
        wr(OFF_WAKE_STS5, 8'hff);
        settle;
        wr(OFF_WAKE_PSTS, 8'h01);
        settle;
        rc(OFF_WAKE_PSTS, 8'h00, "pin clr");
        chk("wake pp idle", 8'h02, {6'h00, wOe, wOut});
        @(posedge clock);
        wakeCtl <= 8'h00;
    endtask
    task automatic s_group;
        wr(OFF_MGMT_EN1, 8'h02);
        wr(OFF_MGMT_EN2, 8'he0);
        wr(OFF_MGMT_CTL, 8'h04);
        wr(OFF_WAKE_EN3, 8'h08);
        @(posedge clock);
        devEvent <= 8'h02;
        settle;
        rc(OFF_MGMT_STS1, 8'h02, "dev live");
        wr(OFF_MGMT_STS1, 8'hff);
        rc(OFF_MGMT_STS1, 8'h02, "dev no w1c");
        rc(OFF_WAKE_STS3, 8'h08, "group mirror");
        rc(OFF_WAKE_PSTS, 8'h01, "group wake");
        chk("ser irq", 8'h01, {7'h00, serIrq2Req});
        chk("mgmt line", 8'h00, {7'h00, mgmtLine});
        wr(OFF_MGMT_EN1, 8'h00);
        settle;
        chk("gated off", 8'h00, {7'h00, serIrq2Req});
        wr(OFF_MGMT_EN1, 8'h02);
        @(posedge clock);
        devEvent <= 8'h00;
        settle;
        rc(OFF_MGMT_STS1, 8'h00, "dev source");
        rc(OFF_WAKE_STS3, 8'h00, "group idle");
        chk("mgmt idle", 8'h01, {7'h00, mgmtLine});
    endtask
    task automatic s_ir_mon;
        @(posedge clock);
        devEvent <= 8'h01;
        repeat (4) @(posedge clock);
        devEvent <= 8'h00;
        settle;
        rc(OFF_MGMT_STS2, 8'h01, "ir latch");
        rc(OFF_MGMT_STS2, 8'h00, "ir read clr");
        @(posedge clock);
        hwmEvent <= 2'b01;
        tachIn <= 2'b01;
        settle;
        rc(OFF_WAKE_STS6, 8'h01, "hwm set");
        rc(OFF_MGMT_STS4, 8'h01, "tach set");
        wr(OFF_WAKE_STS6, 8'hff);
        rc(OFF_WAKE_STS6, 8'h00, "hwm clr");
        wr(OFF_MGMT_STS4, 8'hff);
        rc(OFF_MGMT_STS4, 8'h00, "tach clr");
    endtask
    task automatic s_latch;
        wr(OFF_MGMT_EN3, 8'h02);
        wr(OFF_MGMT_EN4, 8'h02);
        @(posedge clock);
        gpioIn <= 8'h03;
        tachIn <= 2'b11;
        settle;
        // the pin falls again; only the latched gpio and tach bits keep the irq up
        setGpio(8'h01);
        chk("latched irq", 8'h01, {7'h00, serIrq2Req});
        wr(OFF_MGMT_STS3, 8'h02);
        settle;
        chk("tach irq", 8'h01, {7'h00, serIrq2Req});
        wr(OFF_MGMT_STS4, 8'h02);
        settle;
        chk("latched clr", 8'h00, {7'h00, serIrq2Req});
        wr(OFF_MGMT_EN2, 8'he1);
        @(posedge clock);
        devEvent <= 8'h01;
        repeat (4) @(posedge clock);
        devEvent <= 8'h00;
        settle;
        chk("ir irq", 8'h01, {7'h00, serIrq2Req});
        rc(OFF_MGMT_STS2, 8'h01, "ir irq read");
        settle;
        chk("ir irq clr", 8'h00, {7'h00, serIrq2Req});
    endtask
    task automatic s_midrst;
        // pins low first, so no edge is seen right after the reset
        @(posedge clock);
        gpioIn <= 8'h00;
        tachIn <= 2'b00;
        hwmEvent <= 2'b00;
        settle;
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        chk("rerst wake pin", 8'h00, {6'h00, wOe, wOut});
        chk("rerst ser irq", 8'h00, {7'h00, serIrq2Req});
        rc(OFF_WAKE_PSTS, 8'h00, "rerst pin sts");
        rc(OFF_MGMT_EN2, RST_ZERO, "rerst en2");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        s_reset;
        s_gpio;
        s_wake;
        s_group;
        s_ir_mon;
        s_latch;
        s_midrst;
        close_out;
    end
endmodule
